// File: inc/mff_pkg.sv
// shared constants, types and encodings of the multicast filter and flow control block
package mff_pkg;

  // ****************************************
  // command and response type codes
  // ****************************************
  localparam logic [7:0] CMD_EN_MC = 8'h12;
  localparam logic [7:0] CMD_DIS_MC = 8'h13;
  localparam logic [7:0] CMD_FLOW = 8'h14;
  localparam logic [7:0] RSP_TYPE_BIT = 8'h80;

  localparam logic [15:0] RSP_OK = 16'h0000;
  localparam logic [15:0] RSP_FAILED = 16'h0001;
  localparam logic [15:0] RSP_UNSUPPORTED = 16'h0003;
  localparam logic [15:0] REASON_NONE = 16'h0000;
  localparam logic [15:0] REASON_UNKNOWN_CMD = 16'h0001;
  localparam logic [15:0] REASON_INVALID_PARAM = 16'h0002;
  localparam logic [15:0] REASON_FC_NOT_INDEP = 16'h0009;

  // ****************************************
  // field positions and encodings
  // ****************************************
  localparam int SET_DHCP_BIT = 2;
  localparam logic [31:0] SET_DEFINED_MASK = 32'h0000_0007;
  localparam logic [4:0] PKG_WIDE_CHAN = 5'h1f;
  localparam logic [7:0] FC_OFF = 8'h00;
  localparam logic [7:0] FC_GEN = 8'h01;
  localparam logic [7:0] FC_ACCEPT = 8'h02;
  localparam logic [7:0] FC_BOTH = 8'h03;

  localparam logic [47:0] MAC_DHCP_RELAY = 48'h3333_0001_0002;
  localparam logic [47:0] MAC_DHCP_SERVER = 48'h3333_0001_0003;
  localparam logic [15:0] ETYPE_IPV6 = 16'h86dd;
  localparam logic [7:0] NEXT_HDR_UDP = 8'h11;
  localparam logic [15:0] UDP_PORT_DHCP = 16'h0223;
  localparam int MAC_GROUP_BIT = 40;

  // ****************************************
  // values after reset
  // ****************************************
  localparam logic MC_FILTER_RST = 1'b1;
  localparam logic [31:0] SETTINGS_RST = 32'h0000_0000;
  localparam logic [7:0] FC_MODE_RST = 8'h00;

  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned HOLD_LIMIT_MS = 2;
  localparam int unsigned HOLD_LIMIT_CYC = (HOLD_LIMIT_MS * 1000000) / CLK_PERIOD_NS;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic [7:0] cmdType;
    logic [2:0] pkgNum;
    logic [4:0] chanNum;
    logic [31:0] word;
  } mff_cmd_t;

  typedef struct packed {
    logic [7:0] rspType;
    logic [15:0] code;
    logic [15:0] reason;
  } mff_rsp_t;

  typedef struct packed {
    logic [47:0] dstMac;
    logic [15:0] etherType;
    logic [7:0] nextHdr;
    logic [15:0] udpDstPort;
    logic addrFilterHit;
  } mff_frame_t;

  typedef enum logic [1:0] {XS_IDLE, XS_PAUSE, XS_WAIT} mff_xstate_t;

endpackage

// File: logic/mff_xoff_timer.sv
// per-channel xoff request timer bounded by the pause hold limit interval
`timescale 1ns/1ps
`default_nettype none
module mff_xoff_timer import mff_pkg::*; #(
  parameter int unsigned HOLD_CYC = HOLD_LIMIT_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // control
  input wire logic genEnable,
  input wire logic congested,
  // request to the package
  output logic xoffReq
);

  typedef struct packed {
    mff_xstate_t state;
    logic [31:0] cnt;
    logic armed;
    logic req;
  } mff_xt_state_t;

  mff_xt_state_t st_r;
  mff_xt_state_t st_nxt;

  generate
    if (HOLD_CYC < 2) begin : gBadHold
      $error("HOLD_CYC must be at least 2");
    end
  endgenerate

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    st_nxt = st_r;
    st_nxt.cnt = st_r.cnt + 32'h1;
    if (!congested) begin
      st_nxt.armed = 1'b1;
    end
    case (st_r.state)
      XS_IDLE: begin
        st_nxt.req = 1'b0;
        st_nxt.cnt = 32'h0;
        if (genEnable && congested && st_r.armed) begin
          st_nxt.state = XS_PAUSE;
          st_nxt.req = 1'b1;
          st_nxt.armed = 1'b0;
        end
      end
      XS_PAUSE: begin
        // request stands one interval at most
        if (!congested || !genEnable) begin
          st_nxt.state = XS_IDLE; // RULE12
          st_nxt.req = 1'b0;
        end else if (st_r.cnt == HOLD_CYC - 1) begin
          st_nxt.state = XS_WAIT; // RULE12
          st_nxt.req = 1'b0;
          st_nxt.cnt = 32'h0;
        end
      end
      XS_WAIT: begin
        // second interval over and still congested: back to initial state
        if (!congested || !genEnable || st_r.cnt == HOLD_CYC - 1) begin
          st_nxt.state = XS_IDLE; // RULE13
          st_nxt.req = 1'b0;
        end
      end
      default: begin
        st_nxt.state = XS_IDLE;
        st_nxt.req = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= '{state: XS_IDLE, cnt: 32'h0, armed: 1'b1, req: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign xoffReq = st_r.req;

  // ****************************************
  // checks
  // ****************************************
  logic [31:0] reqRun;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      reqRun <= 32'h0;
    end else begin
      reqRun <= xoffReq ? reqRun + 32'h1 : 32'h0;
    end
  end

  AST_REQ_MAX: assert property (@(posedge core_clk) disable iff (!nrst) // RULE12
    reqRun <= HOLD_CYC) else $error("xoff request held past the hold limit");
  AST_WITHDRAW: assert property (@(posedge core_clk) disable iff (!nrst) // RULE13
    (st_r.state == XS_WAIT && st_r.cnt == HOLD_CYC - 1) |=> (st_r.state == XS_IDLE && !xoffReq))
    else $error("channel did not return to initial state");
  AST_GEN_OFF: assert property (@(posedge core_clk) disable iff (!nrst) // RULE15
    !genEnable |=> !xoffReq) else $error("xoff requested while generation is off");

endmodule // mff_xoff_timer
`default_nettype wire

// File: logic/mff_cmd.sv
// multicast filter and flow control command interpreter with frame filter and xoff merge
// How it works
// (RULE1) settings bit 2 set forwards dhcpv6 relay/server multicasts, clear filters them
// (RULE2) dhcpv6 match needs destination mac 33:33:00:01:00:02 or :03
// (RULE3) it also needs ethertype 0x86dd, next header 17 and udp port 547
// (RULE4) without dhcpv6 support the bit stays 0; such packets need an address hit
// (RULE5) enable command with good checksum and id answers type 0x92, no special reason
// (RULE6) disable command 0x13 makes every multicast frame pass through
// (RULE7) enable and disable exist only where accept-all multicast is supported
// (RULE8) without accept-all, multicasts pass only on an enabled address filter hit
// (RULE9) disable command answers type 0x93 with response and reason codes
// (RULE10) disable command is header, checksum at 16..19, pad to 45, no payload
// (RULE11) flow control 0x14 addresses the package; channel subfield is 0x1f
// (RULE12) a congested channel requests xoff for one hold interval at most
// (RULE13) still congested after a second interval, the channel drops its request
// (RULE14) package keeps xoff while any channel still requests it
// (RULE15) enable field: 0 off, 1 generate, 2 accept, 3 both directions
// (RULE16) enable field is the low byte of word 16..19, upper bytes reserved
// (RULE17) after enable, only protocol-filter or address-filter multicasts pass
// (RULE18) reason 0x9 when transmit and receive cannot be enabled separately
// (RULE19) reserved settings bits or enable values 4..255 are refused, nothing changes
// (RULE20) controller sets only options and modes the channel reports as supported
`timescale 1ns/1ps
`default_nettype none
module mff_cmd import mff_pkg::*; #(
  parameter int unsigned NCH = 4,
  parameter bit ACCEPT_ALL_MC = 1'b1,
  parameter bit DHCP_SUPPORT = 1'b1,
  parameter bit INDEP_FC = 1'b1,
  parameter int unsigned HOLD_CYC = HOLD_LIMIT_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // package identity
  input wire logic [2:0] pkgId,
  // command in
  input wire logic cmdValid,
  input wire mff_cmd_t cmd,
  input wire logic cmdChecksumOk,
  input wire logic cmdIdOk,
  // response out
  output logic rspValid,
  output mff_rsp_t rsp,
  // frame decision
  input wire logic frameValid,
  input wire mff_frame_t frame,
  output logic fwdValid,
  output logic fwdPass,
  // flow control
  input wire logic [NCH-1:0] chanCongested,
  output logic [NCH-1:0] chanXoffReq,
  output logic pkgXoff,
  // configuration view
  output logic mcFilterOn,
  output logic [31:0] mcSettings,
  output logic [7:0] fcMode
);

  typedef struct packed {
    logic rspValid;
    mff_rsp_t rsp;
    logic fwdValid;
    logic fwdPass;
    logic pkgXoff;
    logic mcFilterOn;
    logic [31:0] settings;
    logic [7:0] fcMode;
  } mff_main_state_t;

  mff_main_state_t st_r;
  mff_main_state_t st_nxt;

  generate
    if (NCH < 1 || NCH > 31) begin : gBadNch
      $error("NCH must lie in 1..31");
    end
    if (DHCP_SUPPORT && !ACCEPT_ALL_MC) begin : gBadOpt
      $error("dhcp option needs the global multicast commands");
    end
  endgenerate

  // ****************************************
  // frame classification
  // ****************************************
  logic isMulticast;
  logic dhcpHit;
  logic mcPass;
  logic [31:0] supportedMask;

  assign isMulticast = frame.dstMac[MAC_GROUP_BIT];
  assign dhcpHit = (frame.dstMac == MAC_DHCP_RELAY || frame.dstMac == MAC_DHCP_SERVER) && // RULE2
                   frame.etherType == ETYPE_IPV6 && frame.nextHdr == NEXT_HDR_UDP && // RULE3
                   frame.udpDstPort == UDP_PORT_DHCP; // RULE3
  assign supportedMask = DHCP_SUPPORT ? SET_DEFINED_MASK :
                         (SET_DEFINED_MASK & ~(32'h1 << SET_DHCP_BIT)); // RULE4

  always_comb begin
    if (ACCEPT_ALL_MC && !st_r.mcFilterOn) begin
      mcPass = 1'b1; // RULE6
    end else begin
      // address filter hits always pass; dhcp only when its option bit is set
      mcPass = frame.addrFilterHit || (st_r.settings[SET_DHCP_BIT] && dhcpHit); // RULE1 RULE8 RULE17
    end
  end

  // ****************************************
  // command decode
  // ****************************************
  logic pkgAddressed;
  logic reservedSet;
  logic [7:0] fcReq;

  assign pkgAddressed = cmd.pkgNum == pkgId && cmd.chanNum == PKG_WIDE_CHAN; // RULE11
  assign reservedSet = |(cmd.word & ~SET_DEFINED_MASK);
  assign fcReq = cmd.word[7:0]; // RULE16

  always_comb begin
    st_nxt = st_r;
    st_nxt.rspValid = 1'b0;
    st_nxt.fwdValid = 1'b0;
    st_nxt.pkgXoff = |chanXoffReq; // RULE14
    if (frameValid) begin
      st_nxt.fwdValid = 1'b1;
      st_nxt.fwdPass = isMulticast ? mcPass : 1'b1;
    end
    if (cmdValid && cmdChecksumOk) begin
      st_nxt.rsp.rspType = cmd.cmdType | RSP_TYPE_BIT;
      st_nxt.rsp.code = RSP_OK;
      st_nxt.rsp.reason = REASON_NONE;
      case (cmd.cmdType)
        CMD_EN_MC: begin
          st_nxt.rspValid = cmdIdOk; // RULE5
          if (!ACCEPT_ALL_MC) begin
            st_nxt.rsp.code = RSP_UNSUPPORTED; // RULE7
            st_nxt.rsp.reason = REASON_UNKNOWN_CMD;
          end else if (reservedSet) begin
            st_nxt.rsp.code = RSP_FAILED; // RULE19
            st_nxt.rsp.reason = REASON_INVALID_PARAM;
          end else if (cmdIdOk) begin
            st_nxt.mcFilterOn = 1'b1; // RULE17
            st_nxt.settings = cmd.word & supportedMask; // RULE4
          end
        end
        CMD_DIS_MC: begin
          // the command carries no payload; the word is ignored
          st_nxt.rspValid = cmdIdOk; // RULE9 RULE10
          if (!ACCEPT_ALL_MC) begin
            st_nxt.rsp.code = RSP_UNSUPPORTED; // RULE7
            st_nxt.rsp.reason = REASON_UNKNOWN_CMD;
          end else if (cmdIdOk) begin
            st_nxt.mcFilterOn = 1'b0; // RULE6
          end
        end
        CMD_FLOW: begin
          st_nxt.rspValid = pkgAddressed; // RULE11
          if (fcReq > FC_BOTH) begin
            st_nxt.rsp.code = RSP_FAILED; // RULE19
            st_nxt.rsp.reason = REASON_INVALID_PARAM;
          end else if (!INDEP_FC && (fcReq == FC_GEN || fcReq == FC_ACCEPT)) begin
            st_nxt.rsp.code = RSP_FAILED; // RULE18
            st_nxt.rsp.reason = REASON_FC_NOT_INDEP;
          end else if (pkgAddressed) begin
            st_nxt.fcMode = fcReq; // RULE15
          end
        end
        default: begin
          st_nxt.rspValid = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= '{rspValid: 1'b0, rsp: '0, fwdValid: 1'b0, fwdPass: 1'b0, pkgXoff: 1'b0,
                mcFilterOn: MC_FILTER_RST, settings: SETTINGS_RST, fcMode: FC_MODE_RST};
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************
  // per-channel xoff timers
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : gChan
      mff_xoff_timer #(.HOLD_CYC(HOLD_CYC)) uTimer (
        .core_clk(core_clk),
        .nrst(nrst),
        .genEnable(st_r.fcMode[0]), // RULE15
        .congested(chanCongested[gi]),
        .xoffReq(chanXoffReq[gi])
      );
    end
  endgenerate

  assign rspValid = st_r.rspValid;
  assign rsp = st_r.rsp;
  assign fwdValid = st_r.fwdValid;
  assign fwdPass = st_r.fwdPass;
  assign pkgXoff = st_r.pkgXoff;
  assign mcFilterOn = st_r.mcFilterOn;
  assign mcSettings = st_r.settings;
  assign fcMode = st_r.fcMode;

  // ****************************************
  // checks
  // ****************************************
  logic goodCmd;
  assign goodCmd = cmdValid && cmdChecksumOk && cmdIdOk;

  AST_DHCP_FWD: assert property (@(posedge core_clk) disable iff (!nrst) // RULE1
    (frameValid && isMulticast && dhcpHit && st_r.settings[SET_DHCP_BIT]) |=> (fwdValid && fwdPass))
    else $error("dhcpv6 multicast not forwarded");
  AST_DHCP_BLOCK: assert property (@(posedge core_clk) disable iff (!nrst) // RULE4
    (frameValid && isMulticast && st_r.mcFilterOn && !st_r.settings[SET_DHCP_BIT]
     && !frame.addrFilterHit) |=> (fwdValid && !fwdPass))
    else $error("filtered multicast forwarded");
  AST_DHCP_MATCH: assert property (@(posedge core_clk) disable iff (!nrst) // RULE3
    (frameValid && isMulticast && st_r.mcFilterOn && frame.etherType != ETYPE_IPV6
     && !frame.addrFilterHit) |=> !fwdPass)
    else $error("non ipv6 multicast passed the dhcp filter");
  AST_EN_RSP: assert property (@(posedge core_clk) disable iff (!nrst) // RULE5
    (goodCmd && cmd.cmdType == CMD_EN_MC) |=> (rspValid && rsp.rspType == 8'h92))
    else $error("enable command not answered with 0x92");
  AST_DIS_RSP: assert property (@(posedge core_clk) disable iff (!nrst) // RULE9
    (goodCmd && cmd.cmdType == CMD_DIS_MC) |=> (rspValid && rsp.rspType == 8'h93))
    else $error("disable command not answered with 0x93");
  AST_DIS_ALL: assert property (@(posedge core_clk) disable iff (!nrst) // RULE6
    (ACCEPT_ALL_MC && goodCmd && cmd.cmdType == CMD_DIS_MC) ##1 (frameValid && !goodCmd)
    |=> fwdPass) else $error("multicast dropped after disable");
  AST_BAD_SUM: assert property (@(posedge core_clk) disable iff (!nrst) // RULE5
    (cmdValid && !cmdChecksumOk) |=> !rspValid) else $error("answer to bad checksum");
  AST_RSVD: assert property (@(posedge core_clk) disable iff (!nrst) // RULE19
    (goodCmd && cmd.cmdType == CMD_EN_MC && reservedSet) |=> ($stable(mcSettings)
     && rsp.code == RSP_FAILED)) else $error("reserved settings bits accepted");
  AST_FC_RSVD: assert property (@(posedge core_clk) disable iff (!nrst) // RULE19
    (cmdValid && cmdChecksumOk && cmd.cmdType == CMD_FLOW && fcReq > 8'h03) |=> $stable(fcMode))
    else $error("reserved flow control value accepted");
  AST_FC_INDEP: assert property (@(posedge core_clk) disable iff (!nrst) // RULE18
    (!INDEP_FC && cmdValid && cmdChecksumOk && pkgAddressed && cmd.cmdType == CMD_FLOW
     && fcReq == FC_GEN) |=> (rsp.reason == 16'h0009)) else $error("missing reason 0x9");
  AST_PKG_XOFF: assert property (@(posedge core_clk) disable iff (!nrst) // RULE14
    (|chanXoffReq) |=> pkgXoff) else $error("package left xoff while a channel requests it");

  COV_DHCP: cover property (@(posedge core_clk) disable iff (!nrst)
    frameValid && isMulticast && dhcpHit && st_r.settings[SET_DHCP_BIT]);
  COV_DIS: cover property (@(posedge core_clk) disable iff (!nrst)
    goodCmd && cmd.cmdType == CMD_DIS_MC);
  COV_FLOW: cover property (@(posedge core_clk) disable iff (!nrst)
    cmdValid && cmdChecksumOk && pkgAddressed && cmd.cmdType == CMD_FLOW);
  COV_XOFF: cover property (@(posedge core_clk) disable iff (!nrst) $rose(pkgXoff));

endmodule // mff_cmd
`default_nettype wire

// File: test/mff_mc_model.sv
// management controller model that issues sideband commands
`timescale 1ns/1ps
`default_nettype none
module mff_mc_model import mff_pkg::*; (
  // clock
  input wire logic core_clk,
  // command out
  output logic cmdValid,
  output mff_cmd_t cmd,
  output logic cmdChecksumOk,
  output logic cmdIdOk
);
  initial begin
    cmdValid = 1'b0;
    cmd = '0;
    cmdChecksumOk = 1'b0;
    cmdIdOk = 1'b0;
  end
  // one whole command per call; released lines show inverted garbage
  task automatic send(input logic [7:0] typ, input logic [2:0] pkg, input logic [4:0] chan,
    input logic [31:0] word, input logic csOk, input logic idOk);
    @(posedge core_clk);
    cmdValid <= 1'b1;
    cmd <= '{cmdType: typ, pkgNum: pkg, chanNum: chan, word: word};
    cmdChecksumOk <= csOk;
    cmdIdOk <= idOk;
    @(posedge core_clk);
    cmdValid <= 1'b0;
    cmd <= ~cmd;
    cmdChecksumOk <= ~csOk;
    cmdIdOk <= ~idOk;
  endtask
endmodule // mff_mc_model
`default_nettype wire

// File: test/mff_cmd_test.sv
// self-checking bench of the multicast filter and flow control block
`timescale 1ns/1ps
`default_nettype none
module mff_cmd_test import mff_pkg::*;;
  localparam int HOLD = 10;
  localparam logic [2:0] PKG = 3'h5;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic cmdValid, cmdChecksumOk, cmdIdOk, rspValid, fwdValid, fwdPass, pkgXoff, mcFilterOn;
  mff_cmd_t cmd;
  mff_rsp_t rsp;
  logic frameValid = 1'b0;
  mff_frame_t frame = '0;
  logic [3:0] chanCongested = 4'h0;
  logic [3:0] chanXoffReq;
  logic [31:0] mcSettings;
  logic [7:0] fcMode;
  int errTotal = 0;
  int nChecks = 0;
  logic [31:0] rng = 32'h0000_31ff;
  logic mOn = 1'b1;
  logic [31:0] mSet = 32'h0;
  logic [7:0] mFc = 8'h0;
  logic prevOr = 1'b0;
  // second build without independent transmit/receive flow control
  logic rspValid2;
  mff_rsp_t rsp2;

  mff_cmd #(.NCH(4), .HOLD_CYC(HOLD)) u_dut (.core_clk(core_clk), .nrst(nrst), .pkgId(PKG),
    .cmdValid(cmdValid), .cmd(cmd), .cmdChecksumOk(cmdChecksumOk), .cmdIdOk(cmdIdOk),
    .rspValid(rspValid), .rsp(rsp), .frameValid(frameValid), .frame(frame),
    .fwdValid(fwdValid), .fwdPass(fwdPass), .chanCongested(chanCongested),
    .chanXoffReq(chanXoffReq), .pkgXoff(pkgXoff), .mcFilterOn(mcFilterOn),
    .mcSettings(mcSettings), .fcMode(fcMode));
  mff_cmd #(.NCH(4), .INDEP_FC(1'b0), .HOLD_CYC(HOLD)) u_dut2 (.core_clk(core_clk), .nrst(nrst),
    .pkgId(PKG), .cmdValid(cmdValid), .cmd(cmd), .cmdChecksumOk(cmdChecksumOk),
    .cmdIdOk(cmdIdOk), .rspValid(rspValid2), .rsp(rsp2), .frameValid(frameValid),
    .frame(frame), .fwdValid(), .fwdPass(), .chanCongested(chanCongested), .chanXoffReq(),
    .pkgXoff(), .mcFilterOn(), .mcSettings(), .fcMode());
  mff_mc_model u_mc (.core_clk(core_clk), .cmdValid(cmdValid), .cmd(cmd),
    .cmdChecksumOk(cmdChecksumOk), .cmdIdOk(cmdIdOk));

  always #5 core_clk = ~core_clk;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] nextRand();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    nChecks++;
    if (seen !== exp) begin
      errTotal++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", nChecks, errTotal);
    if (errTotal == 0 && nChecks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // package pause follows the channel requests one cycle later; sampled where settled
  always @(negedge core_clk) begin
    if (nrst) chk(48'(pkgXoff), 48'(prevOr));
    prevOr = nrst ? |chanXoffReq : 1'b0;
  end

  task automatic doCmd(input logic [7:0] typ, input logic [2:0] pkg, input logic [4:0] chan,
    input logic [31:0] word, input logic csOk, input logic idOk);
    logic ans;
    logic [15:0] code;
    logic [15:0] rsn;
    logic [15:0] code2;
    logic [15:0] rsn2;
    ans = csOk && (((typ == 8'h12 || typ == 8'h13) && idOk)
      || (typ == 8'h14 && pkg == PKG && chan == 5'h1f));
    code = 16'h0;
    rsn = 16'h0;
    if (ans && typ == 8'h12) begin
      if (word[31:3] != 29'h0) {code, rsn} = {16'h1, 16'h2};
      else {mOn, mSet} = {1'b1, word};
    end else if (ans && typ == 8'h13) begin
      mOn = 1'b0;
    end else if (ans) begin
      if (word[7:0] > 8'h03) {code, rsn} = {16'h1, 16'h2};
      else mFc = word[7:0];
    end
    {code2, rsn2} = {code, rsn};
    if (ans && typ == 8'h14 && (word[7:0] == 8'h01 || word[7:0] == 8'h02)) begin
      {code2, rsn2} = {16'h1, 16'h9};
    end
    u_mc.send(typ, pkg, chan, word, csOk, idOk);
    #1;
    chk(48'(rspValid), 48'(ans));
    if (ans) chk(48'(rsp), 48'({typ | 8'h80, code, rsn}));
    chk(48'(rspValid2), 48'(ans));
    if (ans) chk(48'(rsp2), 48'({typ | 8'h80, code2, rsn2}));
    chk(48'(mcFilterOn), 48'(mOn));
    chk(48'(mcSettings), 48'(mSet));
    chk(48'(fcMode), 48'(mFc));
  endtask

  task automatic doFrame();
    mff_frame_t f;
    logic [31:0] r;
    logic dh;
    logic ex;
    r = nextRand();
    case (r[1:0])
      2'h0: f.dstMac = 48'h3333_0001_0002;
      2'h1: f.dstMac = 48'h3333_0001_0003;
      2'h2: f.dstMac = 48'h3333_0001_0004;
      default: f.dstMac = {r[31:25], 1'b0, 40'h12_3456_789a};
    endcase
    f.etherType = r[2] ? 16'h86dd : 16'h0800;
    f.nextHdr = r[3] ? 8'h11 : 8'h06;
    f.udpDstPort = r[4] ? 16'h0223 : 16'h0222;
    f.addrFilterHit = (r[7:5] == 3'h0);
    dh = (f.dstMac == 48'h3333_0001_0002 || f.dstMac == 48'h3333_0001_0003)
      && f.etherType == 16'h86dd && f.nextHdr == 8'h11 && f.udpDstPort == 16'h0223;
    ex = !f.dstMac[40] || !mOn || f.addrFilterHit || (mSet[2] && dh);
    @(posedge core_clk);
    frameValid <= 1'b1;
    frame <= f;
    @(posedge core_clk);
    frameValid <= 1'b0;
    frame <= ~f;
    #1;
    chk(48'(fwdValid), 48'h1);
    chk(48'(fwdPass), 48'(ex));
  endtask

  // counts the cycles of one request, bounded
  task automatic congest(input int ch, input int expHi);
    int hi;
    int k;
    hi = 0;
    @(posedge core_clk);
    chanCongested[ch] <= 1'b1;
    for (k = 0; k < 100 && (hi == 0 || chanXoffReq[ch] === 1'b1); k++) begin
      @(posedge core_clk);
      #1;
      if (chanXoffReq[ch] === 1'b1) hi++;
      else if (hi == 0 && k > 3) break;
    end
    if (k == 100) begin
      errTotal++;
      end_sim();
    end
    chk(48'(hi), 48'(expHi));
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    logic [31:0] r;
    logic [7:0] typ;
    int hi;
    repeat (20) @(posedge core_clk);
    #1;
    chk(48'({rspValid, fwdValid, pkgXoff, chanXoffReq, mcFilterOn}), 48'h1);
    chk(48'({mcSettings, fcMode}), 48'h0);
    @(posedge core_clk);
    nrst <= 1'b1;
    doCmd(8'h12, 3'h0, 5'h0, 32'h4, 1'b1, 1'b1);
    repeat (8) doFrame();
    for (int v = 0; v < 6; v++) doCmd(8'h14, PKG, 5'h1f, 32'(v), 1'b1, 1'b1);
    for (int i = 0; i < 300; i++) begin
      r = nextRand();
      typ = 8'h12 + {6'h0, r[1:0]};
      doCmd(typ, (r[9:8] == 2'h0) ? r[12:10] : PKG, (r[14:13] == 2'h0) ? r[19:15] : 5'h1f,
        (r[3:2] == 2'h0) ? nextRand() : {r[31:8] & {24{typ == 8'h14}}, 5'h0, r[6:4]},
        r[22:20] != 3'h0, r[25:23] != 3'h0);
      doFrame();
    end
    doCmd(8'h14, PKG, 5'h1f, 32'hffff_ff01, 1'b1, 1'b1);
    congest(0, HOLD);
    hi = 0;
    repeat (2 * HOLD + 4) begin
      @(posedge core_clk);
      #1;
      if (chanXoffReq[0] !== 1'b0) hi++;
    end
    chk(48'(hi), 48'h0);
    @(posedge core_clk);
    chanCongested <= 4'h2;
    repeat (3) @(posedge core_clk);
    congest(0, HOLD);
    @(posedge core_clk);
    chanCongested <= 4'h0;
    doCmd(8'h14, PKG, 5'h1f, 32'h2, 1'b1, 1'b1);
    congest(2, 0);
    @(posedge core_clk);
    chanCongested <= 4'h0;
    doCmd(8'h14, PKG, 5'h1f, 32'h3, 1'b1, 1'b1);
    congest(2, HOLD);
    end_sim();
  end
endmodule // mff_cmd_test
`default_nettype wire
